// file: logic/status_cond_pkg.sv
package status_cond_pkg;
  // Clock period and the sampling tick that paces every channel.
  localparam longint CLK_PERIOD_PS = 5000;
  localparam longint TICK_TIME_MS = 100;
  localparam int TICK_CYCLES_DEF =
    int'(TICK_TIME_MS * 1000000000 / CLK_PERIOD_PS);
  localparam int TICKS_PER_SEC = 10;
  // Shortest pulse that the hold stages must catch, in ms and in ticks.
  localparam int MIN_PULSE_MS = 200;
  localparam int MIN_PULSE_TICKS = MIN_PULSE_MS / int'(TICK_TIME_MS);
  localparam int PAUSE_TIME_S = 3;
  localparam int PAUSE_TICKS = PAUSE_TIME_S * TICKS_PER_SEC;
  localparam int MUTE_SETTLE_TICKS = 5;
  localparam int TIME_W = 14;
  localparam logic [13:0] TIME_MAX = 14'h270e;
  localparam logic [13:0] CODE_MAX = 14'h270f;
  localparam logic [13:0] CODE_OPEN = 14'h0000;
  localparam int BOARDS = 8;
  localparam int DIGITS = 16;
  localparam logic [3:0] DIGIT_PAUSE = 4'ha;
  localparam logic [3:0] DIGIT_END = 4'hf;

  typedef enum logic [2:0] {
    DIAL_IDLE = 3'b001,
    DIAL_DIGIT = 3'b010,
    DIAL_WAIT = 3'b100
  } dial_state_t;

  // Clamp a time setting to range and drop it to the even step below.
  function automatic logic [13:0] evenTime(input logic [13:0] t);
    logic [13:0] c;
    c = (t > TIME_MAX) ? TIME_MAX : t;
    return {c[13:1], 1'b0};
  endfunction
endpackage

// file: logic/status_channel.sv
`timescale 1ns/1ps
`default_nettype none
module status_channel
  import status_cond_pkg::*;
(
  input wire logic mclk, // System clock.
  input wire logic arst_n, // Asynchronous reset, active low.
  input wire logic tick, // Sampling tick pulse.
  input wire logic rawIn, // Synchronised raw status level.
  input wire logic invert, // Inversion setting.
  input wire logic latchEn, // Hold-until-clear setting.
  input wire logic flashEn, // Hold-until-sent setting.
  input wire logic sent, // ON state was transmitted for display.
  input wire logic statusClear, // Global status clear pulse.
  output logic value, // Conditioned channel value.
  output logic rise, // Rising edge of the value, one cycle.
  output logic fall // Falling edge of the value, one cycle.
);
  logic invNow;
  logic prevInv_reg;
  logic held_reg;
  logic held_next;
  logic flash_reg;
  logic flash_next;
  logic seen_reg;
  logic seen_next;
  logic riseIn;
  logic fallIn;
  logic cond;

  assign invNow = rawIn ^ invert;
  // Both hold stages see the inverted sample, never the raw pin.
  assign riseIn = tick && invNow && !prevInv_reg;
  assign fallIn = tick && !invNow && prevInv_reg;

  always_comb
  begin
    held_next = held_reg;
    if (riseIn)
      held_next = 1'b1;
    else if (statusClear)
      held_next = 1'b0;
    flash_next = flash_reg;
    seen_next = seen_reg;
    if (!flash_reg)
    begin
      seen_next = 1'b0;
      if (riseIn)
        flash_next = 1'b1;
    end
    else
    begin
      if (sent)
        seen_next = 1'b1;
      if (fallIn && (seen_reg || sent))
        flash_next = 1'b0;
    end
    if (latchEn)
      cond = held_next;
    else if (flashEn)
      cond = flash_next;
    else
      cond = invNow;
  end

  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      held_reg <= 1'b0;
      flash_reg <= 1'b0;
      seen_reg <= 1'b0;
    end
    else
    begin
      held_reg <= held_next;
      flash_reg <= flash_next;
      seen_reg <= seen_next;
    end
  end

  // A 100 ms tick samples every 200 ms pulse at least once.
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      prevInv_reg <= 1'b0;
      value <= 1'b0;
      rise <= 1'b0;
      fall <= 1'b0;
    end
    else
    begin
      rise <= tick && cond && !value;
      fall <= tick && !cond && value;
      if (tick)
      begin
        prevInv_reg <= invNow;
        value <= cond;
      end
    end
  end
endmodule
`default_nettype wire

// file: logic/status_channel_conditioning.sv
// Function
// - Inversion complements the raw status input.
// - Hold-until-clear latches ON at rising edge.
// - Status clear drops latched channels until rising.
// - Latching works on the inverted value.
// - Pulses of 200 ms or more are caught.
// - Hold-until-sent keeps ON until transmitted.
// - Release needs transmission and a later fall.
// - Hold-until-sent works on the inverted value.
// - Alarms and muting use the conditioned value.
// - Enabled edge alarms sound until acknowledged.
// - Alarm marker stays until input returns normal.
// - Enabled edges send logger events.
// - Mute source zero means not muted.
// - Muted values are flagged in operations mode.
// - Times 0 to 9998 s, even steps.
// - Link failure raises warning then timeout alarm.
// - Dialing starts after the alarm-to-dial time.
// - Access code zero admits all, else match.
// - Pause entry waits three seconds.
// - One dial number per modem board.
// - Muted while source OFF, then settling delay.
// - Pulsed command ignores new raise or lower.
`timescale 1ns/1ps
`default_nettype none
module status_channel_conditioning
  import status_cond_pkg::*;
#(
  parameter int NCH = 8,
  parameter int MW = $clog2(NCH + 1),
  parameter int TICK_CYCLES = TICK_CYCLES_DEF
)
(
  input wire logic mclk, // System clock, 200 MHz.
  input wire logic arst_n, // Asynchronous reset, active low.
  input wire logic [NCH-1:0] statusIn, // Raw status pins.
  input wire logic [NCH-1:0] invertCfg, // Per-channel inversion.
  input wire logic [NCH-1:0] latchCfg, // Per-channel hold-until-clear.
  input wire logic [NCH-1:0] flashCfg, // Per-channel hold-until-sent.
  input wire logic [NCH-1:0] sentAck, // ON state transmitted, pulse.
  input wire logic statusClear, // Global status clear, pulse.
  input wire logic opsMode, // Operations mode.
  input wire logic [NCH-1:0] alarmRiseEn, // Alarm on rising edge.
  input wire logic [NCH-1:0] alarmFallEn, // Alarm on falling edge.
  input wire logic [NCH-1:0] eventRiseEn, // Event on rising edge.
  input wire logic [NCH-1:0] eventFallEn, // Event on falling edge.
  input wire logic [MW-1:0] muteSrc [NCH], // Muting source, 0 is none.
  input wire logic alarmAck, // Operator acknowledge, pulse.
  input wire logic linkFail, // Master terminal link failed.
  input wire logic [13:0] failsafe_warning_time, // Seconds.
  input wire logic [13:0] failsafe_timeout_time, // Seconds.
  input wire logic [13:0] dialDelay, // Alarm-to-dial seconds.
  input wire logic dialupMode, // Dial-up modems in use.
  input wire logic [2:0] dialBoard, // Modem board to dial.
  input wire logic numWrite, // Store one dial digit, pulse.
  input wire logic [2:0] numBoard, // Board of stored digit.
  input wire logic [3:0] numPos, // Position of stored digit.
  input wire logic [3:0] numDigit, // Digit, pause or end code.
  input wire logic [13:0] access_code, // Site access code.
  input wire logic accessCheck, // Terminal presents a code, pulse.
  input wire logic [13:0] presentedCode, // Code offered by terminal.
  input wire logic raiseReq, // Raise command request, pulse.
  input wire logic lowerReq, // Lower command request, pulse.
  input wire logic [7:0] pulseTicks, // Command pulse width, ticks.
  output logic [NCH-1:0] chanValue, // Conditioned values.
  output logic [NCH-1:0] mutedFlag, // Value shown bracketed.
  output logic [NCH-1:0] alarmMark, // Alarm marker per channel.
  output logic audibleAlarm, // Audible alarm, level.
  output logic eventValid, // Logger event, pulse.
  output logic [MW-1:0] eventChan, // Event channel, from 1.
  output logic eventRising, // Event edge direction.
  output logic failWarn, // Failsafe warning alarm.
  output logic failAlarm, // Failsafe timeout alarm.
  output logic dialBusy, // Dialing in progress.
  output logic dialDigitValid, // Digit to dial, pulse.
  output logic [3:0] dialDigitOut, // Digit value.
  output logic accessGranted, // Access admitted, pulse.
  output logic accessDenied, // Access refused, pulse.
  output logic cmdRaise, // Raise command line.
  output logic cmdLower // Lower command line.
);
  localparam int TW = $clog2(TICK_CYCLES + 1);
  localparam int SW = $clog2(MUTE_SETTLE_TICKS + 1);

  logic [TW-1:0] tickCnt_reg;
  logic tick_reg;
  logic [3:0] secCnt_reg;
  logic secTick_reg;
  logic [NCH-1:0] sync1_reg;
  logic [NCH-1:0] sync2_reg;
  logic [NCH-1:0] chVal;
  logic [NCH-1:0] chRise;
  logic [NCH-1:0] chFall;
  logic [NCH-1:0] srcOn;
  logic [NCH-1:0] muted;
  logic [SW-1:0] settle_reg [NCH];
  logic [NCH-1:0] almHit;
  logic [NCH-1:0] evHit;
  logic [NCH-1:0] markDir_reg;
  logic [NCH-1:0] evPend_reg;
  logic [NCH-1:0] evDir_reg;
  logic [NCH-1:0] evTake;
  logic [13:0] fsSecs_reg;
  logic dialWait_reg;
  logic [13:0] dialSecs_reg;
  logic dialCall_reg;
  logic [3:0] numMem_reg [BOARDS][DIGITS];
  dial_state_t dialState_reg;
  logic [2:0] dialB_reg;
  logic [3:0] dialPos_reg;
  logic [5:0] pauseCnt_reg;
  logic [3:0] curDigit;
  logic [7:0] cmdCnt_reg;

  // Sampling tick and one-second tick.
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      tickCnt_reg <= '0;
      tick_reg <= 1'b0;
      secCnt_reg <= 4'h0;
      secTick_reg <= 1'b0;
    end
    else
    begin
      tick_reg <= (tickCnt_reg == TW'(TICK_CYCLES - 1));
      if (tickCnt_reg == TW'(TICK_CYCLES - 1))
        tickCnt_reg <= '0;
      else
        tickCnt_reg <= tickCnt_reg + 1'b1;
      secTick_reg <= 1'b0;
      if (tick_reg)
      begin
        if (secCnt_reg == 4'(TICKS_PER_SEC - 1))
        begin
          secCnt_reg <= 4'h0;
          secTick_reg <= 1'b1;
        end
        else
          secCnt_reg <= secCnt_reg + 4'h1;
      end
    end
  end

  // The status pins are asynchronous to mclk.
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      sync1_reg <= '0;
      sync2_reg <= '0;
    end
    else
    begin
      sync1_reg <= statusIn;
      sync2_reg <= sync1_reg;
    end
  end

  for (genvar c = 0; c < NCH; c++)
  begin : g_ch
    status_channel u_ch (
      .mclk(mclk),
      .arst_n(arst_n),
      .tick(tick_reg),
      .rawIn(sync2_reg[c]),
      .invert(invertCfg[c]),
      .latchEn(latchCfg[c]),
      .flashEn(flashCfg[c]),
      .sent(sentAck[c]),
      .statusClear(statusClear),
      .value(chVal[c]),
      .rise(chRise[c]),
      .fall(chFall[c])
    );
  end

  // Muting and edge qualification work on the conditioned value.
  always_comb
  begin
    for (int c = 0; c < NCH; c++)
    begin
      if (muteSrc[c] == '0 || int'(muteSrc[c]) > NCH)
        srcOn[c] = 1'b1;
      else
        srcOn[c] = chVal[int'(muteSrc[c]) - 1];
      muted[c] = !srcOn[c] || settle_reg[c] != '0;
      almHit[c] = opsMode && !muted[c] &&
        ((chRise[c] && alarmRiseEn[c]) ||
         (chFall[c] && alarmFallEn[c]));
      evHit[c] = opsMode && !muted[c] &&
        ((chRise[c] && eventRiseEn[c]) ||
         (chFall[c] && eventFallEn[c]));
    end
  end

  // Settling delay lets muted readings recover after the source returns.
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      for (int c = 0; c < NCH; c++)
        settle_reg[c] <= '0;
    end
    else
    begin
      for (int c = 0; c < NCH; c++)
      begin
        if (!srcOn[c])
          settle_reg[c] <= SW'(MUTE_SETTLE_TICKS);
        else if (tick_reg && settle_reg[c] != '0)
          settle_reg[c] <= settle_reg[c] - 1'b1;
      end
    end
  end

  // Alarm output, markers and display flags.
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      audibleAlarm <= 1'b0;
      alarmMark <= '0;
      markDir_reg <= '0;
      mutedFlag <= '0;
      chanValue <= '0;
    end
    else
    begin
      chanValue <= chVal;
      mutedFlag <= muted & {NCH{opsMode}};
      if (|almHit)
        audibleAlarm <= 1'b1;
      else if (alarmAck)
        audibleAlarm <= 1'b0;
      for (int c = 0; c < NCH; c++)
      begin
        // Normal is the level the channel had before the alarm edge.
        if (almHit[c])
        begin
          alarmMark[c] <= 1'b1;
          markDir_reg[c] <= chRise[c];
        end
        else if (tick_reg && chVal[c] != markDir_reg[c])
          alarmMark[c] <= 1'b0;
      end
    end
  end

  // Edges of one tick queue up and leave one per cycle, lowest first.
  always_comb
  begin
    evTake = '0;
    for (int c = NCH - 1; c >= 0; c--)
    begin
      if (evPend_reg[c])
        evTake = NCH'(1) << c;
    end
  end

  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      evPend_reg <= '0;
      evDir_reg <= '0;
      eventValid <= 1'b0;
      eventChan <= '0;
      eventRising <= 1'b0;
    end
    else
    begin
      evPend_reg <= (evPend_reg & ~evTake) | evHit;
      for (int c = 0; c < NCH; c++)
      begin
        if (evHit[c])
          evDir_reg[c] <= chRise[c];
      end
      eventValid <= |evTake;
      for (int c = 0; c < NCH; c++)
      begin
        if (evTake[c])
        begin
          eventChan <= MW'(c + 1);
          eventRising <= evDir_reg[c];
        end
      end
    end
  end

  // Failsafe timers count whole seconds of link failure.
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      fsSecs_reg <= 14'h0000;
      failWarn <= 1'b0;
      failAlarm <= 1'b0;
    end
    else
    begin
      if (!linkFail)
        fsSecs_reg <= 14'h0000;
      else if (secTick_reg && fsSecs_reg != 14'h3fff)
        fsSecs_reg <= fsSecs_reg + 14'h0001;
      failWarn <= linkFail &&
        fsSecs_reg >= evenTime(failsafe_warning_time);
      failAlarm <= linkFail &&
        fsSecs_reg >= evenTime(failsafe_timeout_time);
    end
  end

  // Alarm-to-dial delay; a new alarm during the wait does not restart it.
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      dialWait_reg <= 1'b0;
      dialSecs_reg <= 14'h0000;
      dialCall_reg <= 1'b0;
    end
    else
    begin
      dialCall_reg <= 1'b0;
      if (!dialWait_reg)
      begin
        dialSecs_reg <= 14'h0000;
        if (dialupMode && |almHit)
          dialWait_reg <= 1'b1;
      end
      else if (dialSecs_reg >= evenTime(dialDelay))
      begin
        dialWait_reg <= 1'b0;
        dialCall_reg <= 1'b1;
      end
      else if (secTick_reg)
        dialSecs_reg <= dialSecs_reg + 14'h0001;
    end
  end

  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      for (int b = 0; b < BOARDS; b++)
        for (int d = 0; d < DIGITS; d++)
          numMem_reg[b][d] <= DIGIT_END;
    end
    else if (numWrite)
      numMem_reg[numBoard][numPos] <= numDigit;
  end

  assign curDigit = numMem_reg[dialB_reg][dialPos_reg];

  // Dialer sends one digit per tick; a pause entry holds three seconds.
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      dialState_reg <= DIAL_IDLE;
      dialB_reg <= 3'h0;
      dialPos_reg <= 4'h0;
      pauseCnt_reg <= 6'h00;
      dialBusy <= 1'b0;
      dialDigitValid <= 1'b0;
      dialDigitOut <= 4'h0;
    end
    else
    begin
      dialDigitValid <= 1'b0;
      unique case (dialState_reg)
        DIAL_IDLE:
        begin
          dialPos_reg <= 4'h0;
          if (dialCall_reg)
          begin
            dialB_reg <= dialBoard;
            dialState_reg <= DIAL_DIGIT;
            dialBusy <= 1'b1;
          end
        end
        DIAL_DIGIT:
        begin
          if (tick_reg)
          begin
            if (curDigit == DIGIT_END)
            begin
              dialState_reg <= DIAL_IDLE;
              dialBusy <= 1'b0;
            end
            else if (curDigit == DIGIT_PAUSE)
            begin
              pauseCnt_reg <= 6'(PAUSE_TICKS - 1);
              dialState_reg <= DIAL_WAIT;
            end
            else
            begin
              dialDigitValid <= 1'b1;
              dialDigitOut <= curDigit;
              if (dialPos_reg == 4'(DIGITS - 1))
              begin
                dialState_reg <= DIAL_IDLE;
                dialBusy <= 1'b0;
              end
              else
                dialPos_reg <= dialPos_reg + 4'h1;
            end
          end
        end
        DIAL_WAIT:
        begin
          if (tick_reg)
          begin
            if (pauseCnt_reg != 6'h00)
              pauseCnt_reg <= pauseCnt_reg - 6'h01;
            else if (dialPos_reg == 4'(DIGITS - 1))
            begin
              dialState_reg <= DIAL_IDLE;
              dialBusy <= 1'b0;
            end
            else
            begin
              dialPos_reg <= dialPos_reg + 4'h1;
              dialState_reg <= DIAL_DIGIT;
            end
          end
        end
        default:
        begin
          dialState_reg <= DIAL_IDLE;
          dialBusy <= 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      accessGranted <= 1'b0;
      accessDenied <= 1'b0;
    end
    else
    begin
      accessGranted <= accessCheck && (access_code == CODE_OPEN ||
        presentedCode == access_code);
      accessDenied <= accessCheck && access_code != CODE_OPEN &&
        presentedCode != access_code;
    end
  end

  // Requests that arrive while a pulse runs are dropped, not queued.
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      cmdRaise <= 1'b0;
      cmdLower <= 1'b0;
      cmdCnt_reg <= 8'h00;
    end
    else if (cmdRaise || cmdLower)
    begin
      if (tick_reg)
      begin
        cmdCnt_reg <= cmdCnt_reg - 8'h01;
        if (cmdCnt_reg == 8'h01)
        begin
          cmdRaise <= 1'b0;
          cmdLower <= 1'b0;
        end
      end
    end
    else if (pulseTicks != 8'h00 && (raiseReq || lowerReq))
    begin
      cmdRaise <= raiseReq;
      cmdLower <= !raiseReq;
      cmdCnt_reg <= pulseTicks;
    end
  end
endmodule
`default_nettype wire

// file: bench/status_cond_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module status_cond_asserts #(
  parameter int NCH = 8,
  parameter int MW = 4
)
(
  input wire logic mclk, // Clock.
  input wire logic arst_n, // Reset.
  input wire logic opsMode, // Mode.
  input wire logic alarmAck, // Ack.
  input wire logic linkFail, // Link lost.
  input wire logic dialupMode, // Dial-up.
  input wire logic [13:0] access_code, // Code.
  input wire logic accessCheck, // Check.
  input wire logic [13:0] presentedCode, // Offered.
  input wire logic raiseReq, // Raise.
  input wire logic lowerReq, // Lower.
  input wire logic [7:0] pulseTicks, // Width.
  input wire logic [NCH-1:0] mutedFlag, // Muted.
  input wire logic audibleAlarm, // Alarm.
  input wire logic eventValid, // Event.
  input wire logic [MW-1:0] eventChan, // Event channel.
  input wire logic failWarn, // Warning.
  input wire logic failAlarm, // Timeout.
  input wire logic dialBusy, // Dialing.
  input wire logic dialDigitValid, // Digit.
  input wire logic accessGranted, // Granted.
  input wire logic accessDenied, // Denied.
  input wire logic cmdRaise, // Raise line.
  input wire logic cmdLower // Lower line.
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!arst_n);

  a_access_open: assert property (
    accessCheck && access_code == 14'h0000 |=> accessGranted && !accessDenied)
    else $error("open code refused a terminal");
  a_access_deny: assert property (
    accessCheck && access_code != 14'h0000 && presentedCode != access_code
    |=> accessDenied && !accessGranted) else $error("wrong code admitted");
  a_alarm_hold: assert property (audibleAlarm && !alarmAck |=> audibleAlarm)
    else $error("alarm dropped without ack");
  // Two quiet cycles allow the one-cycle lag of the flop outputs.
  a_fail_clear: assert property (
    !linkFail [*2] |-> !failWarn && !failAlarm) else $error("failsafe stuck");
  a_mute_ops: assert property (|mutedFlag |-> $past(opsMode))
    else $error("muted flag outside operations");
  a_event_chan: assert property (
    eventValid |-> eventChan != 0 && eventChan <= NCH)
    else $error("event channel out of range");
  a_cmd_start: assert property (
    raiseReq && pulseTicks != 8'h00 && !cmdRaise && !cmdLower |=> cmdRaise)
    else $error("raise not started");
  a_cmd_block: assert property (cmdRaise && lowerReq |=> !cmdLower)
    else $error("lower taken during pulse");
  a_dial_busy: assert property (dialDigitValid |-> dialBusy)
    else $error("digit without dialing");
  a_dial_mode: assert property ($rose(dialBusy) |-> dialupMode)
    else $error("dialing without dial-up");
endmodule
bind status_channel_conditioning status_cond_asserts #(.NCH(NCH), .MW(MW))
  status_cond_asserts_inst (.mclk, .arst_n, .opsMode, .alarmAck, .linkFail,
  .dialupMode, .access_code, .accessCheck, .presentedCode, .raiseReq,
  .lowerReq, .pulseTicks, .mutedFlag, .audibleAlarm, .eventValid, .eventChan,
  .failWarn, .failAlarm, .dialBusy, .dialDigitValid, .accessGranted,
  .accessDenied, .cmdRaise, .cmdLower);
`default_nettype wire

// file: bench/display_partner.sv
`timescale 1ns/1ps
`default_nettype none
module display_partner #(
  parameter int NCH = 8
)
(
  input wire logic mclk, // Clock.
  input wire logic arst_n, // Reset.
  input wire logic [NCH-1:0] shown, // Values on display.
  input wire logic [7:0] ackDelay, // Transmit time, cycles.
  output logic [NCH-1:0] sentAck // ON state sent.
);
  logic [7:0] cnt [NCH];
  logic [NCH-1:0] prev;
  // A display reports only the ON it actually fetched, one delay later.
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      sentAck <= '0;
      prev <= '0;
      for (int i = 0; i < NCH; i++) cnt[i] <= 8'h00;
    end
    else
    begin
      prev <= shown;
      for (int i = 0; i < NCH; i++)
      begin
        sentAck[i] <= 1'b0;
        if (shown[i] && !prev[i]) cnt[i] <= ackDelay;
        else if (cnt[i] != 8'h00)
        begin
          cnt[i] <= cnt[i] - 8'h01;
          sentAck[i] <= (cnt[i] == 8'h01);
        end
      end
    end
  end
endmodule
`default_nettype wire

// file: bench/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic mclk = 1'b0;
  logic arst_n, statusClear, opsMode, alarmAck, linkFail, dialupMode;
  logic numWrite, accessCheck, raiseReq, lowerReq, eventValid, eventRising;
  logic failWarn, failAlarm, dialBusy, dialDigitValid, accessGranted;
  logic accessDenied, cmdRaise, cmdLower, audibleAlarm;
  logic [7:0] statusIn, invertCfg, latchCfg, flashCfg, sentAck, chanValue;
  logic [7:0] alarmRiseEn, alarmFallEn, eventRiseEn, eventFallEn;
  logic [7:0] mutedFlag, alarmMark, pulseTicks, ackDelay;
  logic [3:0] muteSrc [8];
  logic [3:0] eventChan, numPos, numDigit, dialDigitOut;
  logic [2:0] dialBoard, numBoard;
  logic [13:0] failsafe_warning_time, failsafe_timeout_time, dialDelay;
  logic [13:0] access_code, presentedCode;
  int err_count = 0;
  int tests_run = 0;
  int cycles = 0;
  int n;

  status_channel_conditioning #(.TICK_CYCLES(20))
    status_channel_conditioning_inst (.mclk, .arst_n, .statusIn, .invertCfg,
    .latchCfg, .flashCfg, .sentAck, .statusClear, .opsMode, .alarmRiseEn,
    .alarmFallEn, .eventRiseEn, .eventFallEn, .muteSrc, .alarmAck, .linkFail,
    .failsafe_warning_time, .failsafe_timeout_time, .dialDelay, .dialupMode,
    .dialBoard, .numWrite, .numBoard, .numPos, .numDigit, .access_code,
    .accessCheck, .presentedCode, .raiseReq, .lowerReq, .pulseTicks,
    .chanValue, .mutedFlag, .alarmMark, .audibleAlarm, .eventValid,
    .eventChan, .eventRising, .failWarn, .failAlarm, .dialBusy,
    .dialDigitValid, .dialDigitOut, .accessGranted, .accessDenied,
    .cmdRaise, .cmdLower);
  display_partner display_partner_inst (.mclk, .arst_n, .shown(chanValue),
    .ackDelay, .sentAck);

  always #2.5 mclk = ~mclk;

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // The run is about 3600 cycles; the ceiling leaves a wide margin.
  always @(posedge mclk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      err_count++;
      wrap_up();
    end
  end

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      err_count++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cyc(input int k);
    repeat (k) @(posedge mclk);
    #1;
  endtask

  task automatic tk(input int k);
    cyc(k * 20);
  endtask

  task automatic waitHi(ref logic s, input int lim);
    n = 0;
    while (s !== 1'b1 && n < lim)
    begin
      cyc(1);
      n++;
    end
  endtask

  task automatic wr(input logic [2:0] b, input logic [3:0] p, d);
    numWrite = 1'b1;
    numBoard = b;
    numPos = p;
    numDigit = d;
    cyc(1);
  endtask

  task automatic t_cond();
    tk(2);
    check(chanValue[0], 1'b1);
    check(chanValue[2], 1'b0);
    check(audibleAlarm, 1'b0);
    statusIn[1] = 1'b1;
    tk(2);
    statusIn[1] = 1'b0;
    tk(2);
    check(chanValue[1], 1'b1);
    statusIn[2] = 1'b0;
    tk(2);
    statusIn[2] = 1'b1;
    tk(2);
    check(chanValue[2], 1'b1);
    statusClear = 1'b1;
    cyc(1);
    statusClear = 1'b0;
    tk(2);
    check(chanValue[2:1], 2'b00);
    $display("cond done");
  endtask

  task automatic t_flash();
    statusIn[3] = 1'b1;
    tk(2);
    statusIn[3] = 1'b0;
    tk(3);
    check(chanValue[3], 1'b1);
    tk(8);
    ackDelay = 8'h02;
    statusIn[3] = 1'b1;
    tk(4);
    statusIn[3] = 1'b0;
    tk(2);
    check(chanValue[3], 1'b0);
    $display("flash done");
  endtask

  task automatic t_alarm();
    opsMode = 1'b1;
    statusIn[4] = 1'b1;
    waitHi(eventValid, 100);
    check(eventChan, 4'h5);
    check(eventRising, 1'b1);
    check(audibleAlarm, 1'b1);
    check(alarmMark[4], 1'b1);
    tk(3);
    check(audibleAlarm, 1'b1);
    alarmAck = 1'b1;
    cyc(1);
    alarmAck = 1'b0;
    cyc(1);
    check(audibleAlarm, 1'b0);
    statusIn[4] = 1'b0;
    waitHi(eventValid, 100);
    check(eventRising, 1'b0);
    tk(1);
    check(alarmMark[4], 1'b0);
    check(mutedFlag[6:5], 2'b01);
    statusIn[5] = 1'b1;
    tk(2);
    check(audibleAlarm, 1'b0);
    statusIn[6] = 1'b1;
    tk(2);
    check(mutedFlag[5], 1'b1);
    tk(6);
    check(mutedFlag[5], 1'b0);
    $display("alarm done");
  endtask

  task automatic t_fail();
    linkFail = 1'b1;
    cyc(600);
    check(failWarn, 1'b0);
    cyc(440);
    check({failWarn, failAlarm}, 2'b10);
    cyc(400);
    check(failAlarm, 1'b1);
    linkFail = 1'b0;
    cyc(2);
    check({failWarn, failAlarm}, 2'b00);
    $display("failsafe done");
  endtask

  task automatic t_acc();
    logic [13:0] cd [3] = '{14'h0000, 14'h270f, 14'h270f};
    logic [13:0] pc [3] = '{14'h04d2, 14'h270f, 14'h270e};
    logic [2:0] ok = 3'b011;
    for (int i = 0; i < 3; i++)
    begin
      access_code = cd[i];
      presentedCode = pc[i];
      accessCheck = 1'b1;
      cyc(1);
      check({accessGranted, accessDenied}, {ok[i], !ok[i]});
    end
    accessCheck = 1'b0;
    $display("access done");
  endtask

  task automatic t_cmd();
    raiseReq = 1'b1;
    cyc(1);
    raiseReq = 1'b0;
    check(cmdRaise, 1'b1);
    lowerReq = 1'b1;
    cyc(1);
    check(cmdLower, 1'b0);
    waitHi(cmdLower, 200);
    lowerReq = 1'b0;
    check(n >= 38 && n <= 62, 1'b1);
    $display("command done");
  endtask

  task automatic t_dial();
    wr(3'h2, 4'h0, 4'h4);
    wr(3'h2, 4'h1, 4'ha);
    wr(3'h2, 4'h2, 4'h7);
    wr(3'h3, 4'h0, 4'h9);
    numWrite = 1'b0;
    dialupMode = 1'b1;
    statusIn[4] = 1'b1;
    cyc(150);
    check(dialBusy, 1'b0);
    waitHi(dialDigitValid, 1000);
    check({dialBusy, dialDigitOut}, 5'h14);
    cyc(1);
    waitHi(dialDigitValid, 1000);
    check(dialDigitOut, 4'h7);
    check(n >= 600, 1'b1);
    cyc(60);
    check(dialBusy, 1'b0);
    $display("dial done");
  endtask

  initial
  begin
    {arst_n, statusClear, opsMode, alarmAck, linkFail, dialupMode} = '0;
    {numWrite, accessCheck, raiseReq, lowerReq} = '0;
    statusIn = 8'h04;
    invertCfg = 8'h05;
    latchCfg = 8'h06;
    flashCfg = 8'h08;
    alarmRiseEn = 8'h31;
    alarmFallEn = 8'h00;
    eventRiseEn = 8'h10;
    eventFallEn = 8'h10;
    muteSrc = '{default: 4'h0};
    muteSrc[5] = 4'h7;
    {numBoard, numPos, numDigit} = '0;
    failsafe_warning_time = 14'h0005;
    failsafe_timeout_time = 14'h0007;
    dialDelay = 14'h0003;
    dialBoard = 3'h2;
    access_code = 14'h0000;
    presentedCode = 14'h0000;
    pulseTicks = 8'h03;
    ackDelay = 8'hc8;
    cyc(20);
    arst_n = 1'b1;
    t_cond();
    t_flash();
    t_alarm();
    t_fail();
    t_acc();
    t_cmd();
    t_dial();
    wrap_up();
  end
endmodule
`default_nettype wire
